// File: usb_port_defines.vh
`ifndef USB_PORT_DEFINES_VH
`define USB_PORT_DEFINES_VH

// ==========================================================
// pin modes
`define MODE_ENC_BIDIR 2'h0
`define MODE_ENC_UNI 2'h1
`define MODE_PM_BIDIR 2'h2
`define MODE_PM_UNI 2'h3
`define MODE_RESET `MODE_ENC_BIDIR

// ==========================================================
// port-level states
`define ST_RX 2'h0
`define ST_TX 2'h1
`define ST_TURN 2'h2

// ==========================================================
// line states as seen on the bus (full speed: j = plus high)
`define LS_SE0 2'h0
`define LS_J 2'h1
`define LS_K 2'h2
`define LS_SE1 2'h3

// ==========================================================
// reset and idle levels
`define TXOE_N_RESET 1'h1
`define PIN_OE_N_RESET 1'h1
`define PIN_VAL_RESET 1'h0
`define PARK_DATA_PLUS 1'h1
`define PARK_SE0_MINUS 1'h0

// ==========================================================
// receive bit positions inside the decoder
`define RXB_DATA 0
`define RXB_PLUS 1
`define RXB_MINUS 2
`define RXB_SE0 3
`define RXB_W 4

`endif

// File: rx_line_decoder.v
`timescale 1ns/1ns
`default_nettype none
`include "usb_port_defines.vh"

module rx_line_decoder (
  // clock and reset
  input wire ref_clk,
  input wire rstn,
  // control
  input wire [1:0] mode,
  input wire sample_en,
  // pin inputs
  input wire shared_a_i,
  input wire shared_b_i,
  input wire rx_plus_buffered,
  input wire rx_minus_buffered,
  input wire rx_differential,
  // decoded receive
  output reg [`RXB_W-1:0] rx_bits_q,
  output reg [1:0] line_state_q,
  output reg valid_q,
  output reg se1_err_q
);

  // ==========================================================
  // source selection per mode
  reg [`RXB_W-1:0] bits_d;
  reg p;
  reg m;

  always @* begin
    p = rx_plus_buffered;
    m = rx_minus_buffered;
    bits_d = {`RXB_W{1'b0}};
    case (mode)
      `MODE_ENC_BIDIR: begin
        // data and se0 arrive on the shared lines
        bits_d[`RXB_DATA] = shared_a_i;
        bits_d[`RXB_SE0] = shared_b_i;
        // plus/minus are not wired in this mode, rebuilt from data and se0
        bits_d[`RXB_PLUS] = shared_a_i & ~shared_b_i;
        bits_d[`RXB_MINUS] = ~shared_a_i & ~shared_b_i;
      end
      `MODE_PM_BIDIR: begin
        // plus/minus on shared lines, data dedicated
        p = shared_a_i;
        m = shared_b_i;
        bits_d[`RXB_DATA] = rx_differential;
        bits_d[`RXB_PLUS] = p;
        bits_d[`RXB_MINUS] = m;
        bits_d[`RXB_SE0] = ~p & ~m;
      end
      default: begin
        // both unidirectional modes use dedicated inputs
        bits_d[`RXB_DATA] = rx_differential;
        bits_d[`RXB_PLUS] = p;
        bits_d[`RXB_MINUS] = m;
        bits_d[`RXB_SE0] = ~p & ~m;
      end
    endcase
  end

  // ==========================================================
  // sampling registers; bits and line state hold while not sampling, valid and se1 error clear
  genvar i;
  generate
    for (i = 0; i < `RXB_W; i = i + 1) begin : g_bit
      always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          rx_bits_q[i] <= 1'b0;
        end else if (sample_en) begin
          rx_bits_q[i] <= bits_d[i];
        end
      end
    end
  endgenerate

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      line_state_q <= `LS_SE0;
      valid_q <= 1'b0;
      se1_err_q <= 1'b0;
    end else begin
      valid_q <= sample_en;
      se1_err_q <= sample_en & bits_d[`RXB_PLUS] & bits_d[`RXB_MINUS];
      if (sample_en) begin
        line_state_q <= {bits_d[`RXB_MINUS], bits_d[`RXB_PLUS]};
      end
    end
  end

endmodule

`default_nettype wire

// File: usb_serial_transceiver_port.v
`timescale 1ns/1ns
`default_nettype none
`include "usb_port_defines.vh"

// Summary of operation
// - four pin modes: two encoded, two plus/minus
// - transmit enable low means device transmits
// - encoded bidir: shared data line turns around
// - encoded bidir: shared se0 line turns around
// - encoded unidir: data and se0 outputs only
// - plus/minus bidir: shared plus line turns around
// - plus/minus bidir: minus line turns, dedicated data
module usb_serial_transceiver_port (
  // clock and reset
  input wire ref_clk,
  input wire rstn,
  // mode selection from the controller
  input wire [1:0] mode_sel,
  // transmit request from the controller line logic
  input wire tx_active,
  input wire tx_data,
  input wire tx_se0,
  input wire tx_plus,
  input wire tx_minus,
  // receive results to the controller line logic
  output wire rx_data_out,
  output wire rx_plus_out,
  output wire rx_minus_out,
  output wire rx_se0_out,
  output wire [1:0] rx_line_state,
  output wire rx_valid,
  output wire rx_se1_err,
  // status
  output wire [1:0] mode_active,
  output wire tx_busy,
  // transceiver control pin
  output wire tx_output_enable_n,
  // first shared line, split into three signals
  output wire line_data_plus_o,
  output wire line_data_plus_oe_n,
  input wire line_data_plus_i,
  // second shared line, split into three signals
  output wire single_ended_zero_minus_o,
  output wire single_ended_zero_minus_oe_n,
  input wire single_ended_zero_minus_i,
  // dedicated receive inputs
  input wire rx_plus_buffered,
  input wire rx_minus_buffered,
  input wire rx_differential
);

  // ==========================================================
  // mode decoding helpers
  function is_bidir;
    input [1:0] m;
    begin
      is_bidir = (m == `MODE_ENC_BIDIR) || (m == `MODE_PM_BIDIR);
    end
  endfunction

  function is_plus_minus;
    input [1:0] m;
    begin
      is_plus_minus = (m == `MODE_PM_BIDIR) || (m == `MODE_PM_UNI);
    end
  endfunction

  // ==========================================================
  // state and registers
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [1:0] mode_q;
  reg [1:0] mode_d;
  reg txoe_n_q;
  reg txoe_n_d;
  reg busy_q;
  reg busy_d;
  reg dp_o_q;
  reg dp_o_d;
  reg dp_oe_n_q;
  reg dp_oe_n_d;
  reg sm_o_q;
  reg sm_o_d;
  reg sm_oe_n_q;
  reg sm_oe_n_d;

  wire sample_en;
  wire [`RXB_W-1:0] rx_bits;
  wire [1:0] ls;
  wire valid;
  wire se1_err;

  // ==========================================================
  // sequencing
  // mode is only taken while receiving, so a transmit never sees
  // its pin roles change under it
  always @* begin
    state_d = state_q;
    mode_d = mode_q;
    case (state_q)
      `ST_RX: begin
        mode_d = mode_sel;
        if (tx_active) begin
          state_d = `ST_TX;
        end
      end
      `ST_TX: begin
        if (!tx_active) begin
          state_d = `ST_TURN;
        end
      end
      `ST_TURN: begin
        // one idle cycle lets the transceiver take the shared lines
        // before receive data is trusted
        if (tx_active) begin
          state_d = `ST_TX;
        end else begin
          state_d = `ST_RX;
        end
      end
      default: begin
        state_d = `ST_RX;
      end
    endcase
  end

  // ==========================================================
  // pin drive
  always @* begin
    busy_d = (state_d == `ST_TX);
    txoe_n_d = ~busy_d;
    if (busy_d) begin
      dp_oe_n_d = 1'b0;
      sm_oe_n_d = 1'b0;
      if (is_plus_minus(mode_d)) begin
        dp_o_d = tx_plus;
        sm_o_d = tx_minus;
      end else begin
        dp_o_d = tx_data;
        sm_o_d = tx_se0;
      end
    end else if (is_bidir(mode_d)) begin
      // transceiver alone drives both shared lines
      dp_oe_n_d = 1'b1;
      sm_oe_n_d = 1'b1;
      dp_o_d = `PIN_VAL_RESET;
      sm_o_d = `PIN_VAL_RESET;
    end else begin
      // outputs only, parked at idle while receiving
      dp_oe_n_d = 1'b0;
      sm_oe_n_d = 1'b0;
      dp_o_d = `PARK_DATA_PLUS;
      sm_o_d = `PARK_SE0_MINUS;
    end
  end

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= `ST_RX;
      mode_q <= `MODE_RESET;
      busy_q <= 1'b0;
      txoe_n_q <= `TXOE_N_RESET;
      dp_o_q <= `PIN_VAL_RESET;
      dp_oe_n_q <= `PIN_OE_N_RESET;
      sm_o_q <= `PIN_VAL_RESET;
      sm_oe_n_q <= `PIN_OE_N_RESET;
    end else begin
      state_q <= state_d;
      mode_q <= mode_d;
      busy_q <= busy_d;
      txoe_n_q <= txoe_n_d;
      dp_o_q <= dp_o_d;
      dp_oe_n_q <= dp_oe_n_d;
      sm_o_q <= sm_o_d;
      sm_oe_n_q <= sm_oe_n_d;
    end
  end

  // ==========================================================
  // receive path
  // sampled only with transmit enable high and past turnaround;
  // this also keeps our own driven levels out of the receive data
  assign sample_en = (state_q == `ST_RX) & txoe_n_q;

  rx_line_decoder u_rx (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .mode(mode_q),
    .sample_en(sample_en),
    .shared_a_i(line_data_plus_i),
    .shared_b_i(single_ended_zero_minus_i),
    .rx_plus_buffered(rx_plus_buffered),
    .rx_minus_buffered(rx_minus_buffered),
    .rx_differential(rx_differential),
    .rx_bits_q(rx_bits),
    .line_state_q(ls),
    .valid_q(valid),
    .se1_err_q(se1_err)
  );

  // ==========================================================
  // outputs, all from flip-flops
  assign rx_data_out = rx_bits[`RXB_DATA];
  assign rx_plus_out = rx_bits[`RXB_PLUS];
  assign rx_minus_out = rx_bits[`RXB_MINUS];
  assign rx_se0_out = rx_bits[`RXB_SE0];
  assign rx_line_state = ls;
  assign rx_valid = valid;
  assign rx_se1_err = se1_err;
  assign mode_active = mode_q;
  assign tx_busy = busy_q;
  assign tx_output_enable_n = txoe_n_q;
  assign line_data_plus_o = dp_o_q;
  assign line_data_plus_oe_n = dp_oe_n_q;
  assign single_ended_zero_minus_o = sm_o_q;
  assign single_ended_zero_minus_oe_n = sm_oe_n_q;

endmodule

`default_nettype wire

// File: usb_port_props.sv
`timescale 1ns/1ns
`default_nettype none
// ==========
// pin checker
module usb_port_props (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // controller side
  input wire logic tx_active,
  input wire logic tx_data,
  input wire logic tx_se0,
  input wire logic tx_plus,
  input wire logic tx_minus,
  input wire logic [1:0] mode_active,
  input wire logic tx_busy,
  input wire logic rx_valid,
  // pins
  input wire logic tx_output_enable_n,
  input wire logic line_data_plus_o,
  input wire logic line_data_plus_oe_n,
  input wire logic single_ended_zero_minus_o,
  input wire logic single_ended_zero_minus_oe_n
);
  wire logic txn = tx_output_enable_n;
  wire logic oa = line_data_plus_oe_n;
  wire logic ob = single_ended_zero_minus_oe_n;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  a_busy_mirror: assert property (tx_busy == !txn)
    else $error("busy differs from enable");
  a_tx_entry: assert property ($fell(txn) |-> $past(tx_active))
    else $error("enable fell without request");
  a_tx_holds: assert property (!txn && tx_active |=> !txn)
    else $error("transmit dropped early");
  a_bidir_release: assert property (txn && !mode_active[0] |-> oa && ob)
    else $error("shared line driven in receive");
  a_tx_drive: assert property (!txn |-> !oa && !ob)
    else $error("line not driven in transmit");
  a_enc_data: assert property (
    !txn && !mode_active[1] |-> line_data_plus_o == $past(tx_data))
    else $error("data pin wrong");
  a_enc_se0: assert property (
    !txn && !mode_active[1] |-> single_ended_zero_minus_o == $past(tx_se0))
    else $error("se0 pin wrong");
  a_pm_plus: assert property (
    !txn && mode_active[1] |-> line_data_plus_o == $past(tx_plus))
    else $error("plus pin wrong");
  a_pm_minus: assert property (
    !txn && mode_active[1] |-> single_ended_zero_minus_o == $past(tx_minus))
    else $error("minus pin wrong");
  a_uni_drive: assert property (mode_active[0] |-> !oa && !ob)
    else $error("output only pin released");
  a_rx_gated: assert property (rx_valid |-> $past(txn))
    else $error("sampled while transmitting");
endmodule
bind usb_serial_transceiver_port usb_port_props usb_port_props_i (.*);
`default_nettype wire

// File: xcvr_model.sv
`timescale 1ns/1ns
`default_nettype none
// ==========
// transceiver model
module xcvr_model (
  // clock, line state {minus, plus}, mode strap
  input wire logic ref_clk,
  input wire logic [1:0] ls,
  input wire logic [1:0] mode,
  // device pins
  input wire logic txoe_n,
  input wire logic a_o,
  input wire logic a_oe_n,
  input wire logic b_o,
  input wire logic b_oe_n,
  // resolved and dedicated lines
  output logic a_i,
  output logic b_i,
  output logic vp1,
  output logic vm1,
  output logic rcv
);
  // released lines toggle so a stale value never matches
  logic t = 1'b0;
  wire logic own = txoe_n & ~mode[0];
  wire logic pb = mode[1] ? ls[1] : ~|ls;
  always @(posedge ref_clk) t <= ~t;
  assign a_i = ~a_oe_n ? a_o : (own ? ls[0] : t);
  assign b_i = ~b_oe_n ? b_o : (own ? pb : ~t);
  assign vp1 = txoe_n ? ls[0] : t;
  assign vm1 = txoe_n ? ls[1] : ~t;
  assign rcv = txoe_n ? ls[0] : t;
endmodule
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin errors++; \
  $display("unexpected %s expected %0h seen %0h", n, e, a); end end
module tb_top;
  // ==========
  // signals
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [1:0] mode_sel = 2'h0;
  logic [1:0] ls = 2'h1;
  logic tx_active = 1'b0;
  logic tx_data = 1'b0;
  logic tx_se0 = 1'b0;
  logic tx_plus = 1'b0;
  logic tx_minus = 1'b0;
  wire logic rx_data_out, rx_plus_out, rx_minus_out, rx_se0_out, rx_valid, rx_se1_err;
  wire logic [1:0] rx_line_state, mode_active;
  wire logic tx_busy, tx_output_enable_n, line_data_plus_o, line_data_plus_oe_n;
  wire logic line_data_plus_i, single_ended_zero_minus_o, single_ended_zero_minus_oe_n;
  wire logic single_ended_zero_minus_i, rx_plus_buffered, rx_minus_buffered, rx_differential;
  wire logic [5:0] gtx = {tx_output_enable_n, line_data_plus_oe_n, single_ended_zero_minus_oe_n,
    line_data_plus_o, single_ended_zero_minus_o, tx_busy};
  wire logic [7:0] grx = {rx_data_out, rx_plus_out, rx_minus_out, rx_se0_out,
    rx_line_state, rx_se1_err, rx_valid};
  integer errors = 0;
  integer checks = 0;
  integer st = 3;
  logic [1:0] md = 2'h0;
  logic [7:0] erx = 8'h0;
  logic [5:0] etx = 6'h38;
  usb_serial_transceiver_port usb_serial_transceiver_port_i (.*);
  xcvr_model xcvr_model_i (.ref_clk(ref_clk), .ls(ls), .mode(mode_active),
    .txoe_n(tx_output_enable_n), .a_o(line_data_plus_o), .a_oe_n(line_data_plus_oe_n),
    .b_o(single_ended_zero_minus_o), .b_oe_n(single_ended_zero_minus_oe_n),
    .a_i(line_data_plus_i), .b_i(single_ended_zero_minus_i), .vp1(rx_plus_buffered),
    .vm1(rx_minus_buffered), .rcv(rx_differential));
  initial forever #25 ref_clk = ~ref_clk;
  // ==========
  // reference model, state 3 is the first edge after reset and samples like receive
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st = 3;
      md = 2'h0;
      erx = 8'h0;
      etx = 6'h38;
    end else begin
      if (st == 3 || st == 0) md = mode_sel;
      if (st % 3 == 0) erx = {ls[0], ls[0], ls[1], ~|ls, ls[1], ls[0], &ls, 1'b1};
      else erx[1:0] = 2'h0;
      st = tx_active ? 1 : (st == 1 ? 2 : 0);
      if (st == 1) etx = {3'h0, md[1] ? tx_plus : tx_data, md[1] ? tx_minus : tx_se0, 1'b1};
      else etx = {1'b1, ~md[0], ~md[0], md[0], 2'h0};
    end
    #1;
    `CHK("pins", etx, gtx)
    `CHK("rx", erx, grx)
    `CHK("mode", md, mode_active)
  end
  // ==========
  // stimulus: mode held only where it is taken
  task cyc(input integer m, input integer n);
    integer i;
    for (i = 0; i < n; i++) begin
      @(posedge ref_clk);
      #2;
      tx_active = tx_active ^ ($urandom % 6 == 0);
      {tx_data, tx_se0, tx_plus, tx_minus} = 4'($urandom);
      mode_sel = (st % 3) ? 2'($urandom) : 2'(m);
      // mode 0 cannot carry both lines high; sampling uses the mode in force
      ls = 2'($urandom % (mode_active != 2'h0 ? 4 : 3));
    end
  endtask
  task end_sim;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    integer m;
    void'($urandom(32'h0d81));
    repeat (2) @(posedge ref_clk);
    #2 rstn = 1'b1;
    for (m = 0; m < 4; m++) begin
      cyc(m, 400);
      $display("test mode %0d done", m);
    end
    rstn = 1'b0;
    cyc(2, 2);
    rstn = 1'b1;
    cyc(2, 200);
    $display("test reset done");
    end_sim;
  end
  initial begin
    #1000000;
    errors++;
    end_sim;
  end
endmodule
`default_nettype wire
